// *** design/hbid_pkg.sv ***
// Constants and carrier types for the host bus interface decoder
//
// What this block does
// - Two straps pick the bus style, both low giving separate read/write strobes and first high, second low giving enable clock plus direction line.
// - A read with the data-type line low returns status, and with it high returns display data or cursor address.
// - A write with the data-type line low is display data or parameter, and with it high is a command code.
// - In strobe style a read is read strobe low with write strobe high, and data drivers are on only while the read strobe is active.
// - In strobe style a write is write strobe low with read strobe high.
// - In enable style the transfer happens while the enable clock is high and the bus is ignored while it is low.
// - In enable style the direction line high means device drives data, low means host writes.
// - Accesses are accepted only while the active-low chip select is asserted.
// - The data bus is an 8-bit tristate bus driven by the device only during reads.
// - The reset input returns the host port and internal state to their initial condition.
package hbid_pkg;

  localparam int DATA_W = 8;

  // Strap codes
  localparam logic [1:0] STRAP_STROBE = 2'h0;
  localparam logic [1:0] STRAP_ENABLE = 2'h1;

  // Data-type line levels
  localparam logic DTYPE_LOW  = 1'b0;
  localparam logic DTYPE_HIGH = 1'b1;

  localparam logic [DATA_W-1:0] BYTE_RESET = 8'h00;

  // Decoded access kinds
  typedef enum logic [2:0]
  {
    KIND_IDLE   = 3'b000,
    KIND_STATUS = 3'b001,
    KIND_DATA_R = 3'b010,
    KIND_DATA_W = 3'b011,
    KIND_CMD_W  = 3'b100
  } hbid_kind_type;

  // Written byte handed to the core
  typedef struct packed
  {
    logic              is_cmd;
    logic [DATA_W-1:0] value;
  } hbid_wr_type;

endpackage

// *** design/hbid_top.sv ***
// Host bus port: style select, access decode, write capture and read drive
`timescale 1ns/1ps
module hbid_top
(
  input  wire logic                          CLOCK_I,
  input  wire logic                          RST_N_I,
  input  wire logic                          CLK_EN_I,
  input  wire logic                          IFACE_PICK_A_I,
  input  wire logic                          IFACE_PICK_B_I,
  input  wire logic                          CHIP_SEL_N_I,
  input  wire logic                          DATA_TYPE_LINE_I,
  input  wire logic                          RD_STROBE_N_OR_EN_I,
  input  wire logic                          WR_STROBE_N_OR_DIR_I,
  input  wire logic                          HW_CLEAR_IN_N_I,
  input  wire logic [hbid_pkg::DATA_W-1:0]   HOST_DATA_BUS_I,
  output logic      [hbid_pkg::DATA_W-1:0]   HOST_DATA_BUS_O,
  output logic                               HOST_DATA_BUS_OE_O,
  input  wire logic [hbid_pkg::DATA_W-1:0]   STATUS_I,
  input  wire logic [hbid_pkg::DATA_W-1:0]   RD_DATA_I,
  output hbid_pkg::hbid_wr_type              WR_O,
  output logic                               WR_VALID_O,
  output hbid_pkg::hbid_kind_type            KIND_O,
  output logic                               RD_STROBE_O
);

  logic                    rst_n;
  logic                    enable_style;
  logic                    sel;
  logic                    rd_act;
  logic                    wr_act;
  logic                    wr_act_q;
  logic                    rd_act_q;
  logic                    dtype_q;
  logic [hbid_pkg::DATA_W-1:0] wbyte_q;
  logic [hbid_pkg::DATA_W-1:0] rdata_q;
  hbid_pkg::hbid_wr_type   wr_q;
  logic                    wr_valid_q;
  hbid_pkg::hbid_kind_type kind_d;
  hbid_pkg::hbid_kind_type kind_q;

  // Hardware clear pin acts like the main reset; combined before any flop
  assign rst_n = RST_N_I & HW_CLEAR_IN_N_I;

  // Straps are wired to rails, so no sampling; unknown codes fall back to strobe style
  assign enable_style = ({IFACE_PICK_B_I, IFACE_PICK_A_I} == hbid_pkg::STRAP_ENABLE);
  assign sel = ~CHIP_SEL_N_I;

  // Read and write qualifiers per style; chip select gates everything
  always_comb
  begin
    if (!sel)
    begin
      rd_act = 1'b0;
      wr_act = 1'b0;
    end
    else if (enable_style)
    begin
      rd_act = RD_STROBE_N_OR_EN_I & WR_STROBE_N_OR_DIR_I;
      wr_act = RD_STROBE_N_OR_EN_I & ~WR_STROBE_N_OR_DIR_I;
    end
    else
    begin
      rd_act = ~RD_STROBE_N_OR_EN_I & WR_STROBE_N_OR_DIR_I;
      wr_act = RD_STROBE_N_OR_EN_I & ~WR_STROBE_N_OR_DIR_I;
    end
  end

  // Access decode from direction and data-type line
  always_comb
  begin
    if (rd_act)
      kind_d = DATA_TYPE_LINE_I ? hbid_pkg::KIND_DATA_R : hbid_pkg::KIND_STATUS;
    else if (wr_act)
      kind_d = DATA_TYPE_LINE_I ? hbid_pkg::KIND_CMD_W : hbid_pkg::KIND_DATA_W;
    else
      kind_d = hbid_pkg::KIND_IDLE;
  end

  // Track the write phase; byte and data-type latched each active cycle so the
  // last value before the strobe's trailing edge is the one delivered
  always_ff @(posedge CLOCK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_act_q <= 1'b0;
      wbyte_q  <= hbid_pkg::BYTE_RESET;
      dtype_q  <= hbid_pkg::DTYPE_LOW;
    end
    else if (CLK_EN_I)
    begin
      wr_act_q <= wr_act;
      if (wr_act)
      begin
        wbyte_q <= HOST_DATA_BUS_I;
        dtype_q <= DATA_TYPE_LINE_I;
      end
    end
  end

  // Deliver one pulse at the end of the write phase (strobe rise or enable fall)
  always_ff @(posedge CLOCK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_q       <= '0;
      wr_valid_q <= 1'b0;
    end
    else if (CLK_EN_I)
    begin
      wr_valid_q <= wr_act_q & ~wr_act;
      if (wr_act_q & ~wr_act)
      begin
        wr_q.value  <= wbyte_q;
        wr_q.is_cmd <= (dtype_q == hbid_pkg::DTYPE_HIGH);
      end
    end
  end

  // Read data is registered; the decode kind is registered for the core
  always_ff @(posedge CLOCK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata_q  <= hbid_pkg::BYTE_RESET;
      kind_q   <= hbid_pkg::KIND_IDLE;
      rd_act_q <= 1'b0;
    end
    else if (CLK_EN_I)
    begin
      kind_q   <= kind_d;
      rd_act_q <= rd_act;
      if (rd_act)
        rdata_q <= DATA_TYPE_LINE_I ? RD_DATA_I : STATUS_I;
    end
  end

  // Drivers follow the live read qualifier so they release as soon as the
  // strobe ends; data lags one cycle, a trade for registered outputs
  assign HOST_DATA_BUS_O    = rdata_q;
  assign HOST_DATA_BUS_OE_O = rd_act;
  assign WR_O               = wr_q;
  assign WR_VALID_O         = wr_valid_q;
  assign KIND_O             = kind_q;
  assign RD_STROBE_O        = rd_act & ~rd_act_q; // Start of a read, for the core

  // Select gating: nothing may reach the bus or the core without chip select
  a_oe_needs_select: assert property (
    @(posedge CLOCK_I) disable iff (!rst_n)
    HOST_DATA_BUS_OE_O |-> !CHIP_SEL_N_I)
    else $error("drivers on without chip select");

  a_deselect_quiet: assert property (
    @(posedge CLOCK_I) disable iff (!rst_n)
    CHIP_SEL_N_I |-> (!HOST_DATA_BUS_OE_O && kind_d == hbid_pkg::KIND_IDLE))
    else $error("activity while deselected");

  // Strobe style qualifiers
  a_strobe_read_oe: assert property (
    @(posedge CLOCK_I) disable iff (!rst_n)
    (!enable_style && sel) |->
    (HOST_DATA_BUS_OE_O == (!RD_STROBE_N_OR_EN_I && WR_STROBE_N_OR_DIR_I)))
    else $error("strobe style drive mismatch");

  a_strobe_write_kind: assert property (
    @(posedge CLOCK_I) disable iff (!rst_n)
    (!enable_style && sel && RD_STROBE_N_OR_EN_I && !WR_STROBE_N_OR_DIR_I) |->
    (kind_d == hbid_pkg::KIND_DATA_W || kind_d == hbid_pkg::KIND_CMD_W))
    else $error("strobe style write misdecoded");

  // Enable style qualifiers
  a_enable_low_idle: assert property (
    @(posedge CLOCK_I) disable iff (!rst_n)
    (enable_style && !RD_STROBE_N_OR_EN_I) |-> (kind_d == hbid_pkg::KIND_IDLE))
    else $error("bus used while enable low");

  a_enable_dir_read: assert property (
    @(posedge CLOCK_I) disable iff (!rst_n)
    (enable_style && sel && RD_STROBE_N_OR_EN_I) |->
    (HOST_DATA_BUS_OE_O == WR_STROBE_N_OR_DIR_I))
    else $error("direction line not honoured");

  a_enable_write_kind: assert property (
    @(posedge CLOCK_I) disable iff (!rst_n)
    (enable_style && sel && RD_STROBE_N_OR_EN_I && !WR_STROBE_N_OR_DIR_I) |->
    (kind_d == hbid_pkg::KIND_DATA_W || kind_d == hbid_pkg::KIND_CMD_W))
    else $error("enable style write misdecoded");

  // Read data source follows the data-type line; read start pulse lasts one cycle
  a_read_status_sel: assert property (
    @(posedge CLOCK_I) disable iff (!rst_n)
    (CLK_EN_I && rd_act && !DATA_TYPE_LINE_I) |=>
    (HOST_DATA_BUS_O == $past(STATUS_I)))
    else $error("status not returned");

  a_read_data_sel: assert property (
    @(posedge CLOCK_I) disable iff (!rst_n)
    (CLK_EN_I && rd_act && DATA_TYPE_LINE_I) |=>
    (HOST_DATA_BUS_O == $past(RD_DATA_I)))
    else $error("display data not returned");

  a_read_start_pulse: assert property (
    @(posedge CLOCK_I) disable iff (!rst_n)
    (RD_STROBE_O && CLK_EN_I) |=> !RD_STROBE_O)
    else $error("read start pulse longer than one cycle");

  // Write decode and delivery
  a_write_kind: assert property (
    @(posedge CLOCK_I) disable iff (!rst_n)
    (wr_act && DATA_TYPE_LINE_I) |-> (kind_d == hbid_pkg::KIND_CMD_W))
    else $error("command write misdecoded");

  a_write_capture: assert property (
    @(posedge CLOCK_I) disable iff (!rst_n)
    (CLK_EN_I && wr_act ##1 CLK_EN_I && !wr_act) |=>
    (WR_VALID_O && WR_O.value == $past(wbyte_q)))
    else $error("write byte not delivered at strobe end");

  a_write_type_flag: assert property (
    @(posedge CLOCK_I) disable iff (!rst_n)
    (CLK_EN_I && wr_act ##1 CLK_EN_I && !wr_act) |=>
    (WR_O.is_cmd == $past(DATA_TYPE_LINE_I, 2)))
    else $error("write type flag not taken from last active cycle");

  a_write_single: assert property (
    @(posedge CLOCK_I) disable iff (!rst_n)
    WR_VALID_O && CLK_EN_I |=> !WR_VALID_O)
    else $error("write pulse longer than one cycle");

  // Clock enable low must freeze the write pulse, access kind and read data outputs
  a_enable_freeze: assert property (
    @(posedge CLOCK_I) disable iff (!rst_n)
    !CLK_EN_I |=> ($stable(WR_VALID_O) && $stable(KIND_O) && $stable(HOST_DATA_BUS_O)))
    else $error("registered outputs moved while clock enable low");

endmodule

// *** dv/hbid_host_model.sv ***
// Processor bus model: select, data-type line, strobes and byte bus
`timescale 1ns/1ps
module hbid_host_model
(
  input  wire logic        clk_i,
  input  wire logic        mode_e_i,
  input  wire logic [7:0]  dev_data_i,
  input  wire logic        dev_oe_i,
  output logic             cs_n_o,
  output logic             dtype_o,
  output logic             rd_o,
  output logic             wr_o,
  output logic      [7:0]  bus_o
);
  logic [7:0] drv_q;

  // Device wins while enabled; a released host byte is inverted, never held
  assign bus_o = dev_oe_i ? dev_data_i : drv_q;

  // Idle levels at time zero
  initial
  begin
    cs_n_o = 1'b1;
    dtype_o = 1'b0;
    rd_o = 1'b1;
    wr_o = 1'b1;
    drv_q = 8'h00;
  end

  // Holds one access for three sampled cycles, samples the bus, then releases
  task automatic access(input logic is_wr, input logic dt, input logic sel,
                        input logic [7:0] b, output logic [7:0] q, output logic oe);
    @(posedge clk_i);
    cs_n_o <= ~sel;
    dtype_o <= dt;
    rd_o <= mode_e_i | is_wr;
    wr_o <= ~is_wr;
    drv_q <= is_wr ? b : ~drv_q;
    repeat (3) @(posedge clk_i);
    q = bus_o;
    oe = dev_oe_i;
    cs_n_o <= 1'b1;
    rd_o <= ~mode_e_i;
    wr_o <= 1'b1;
    drv_q <= ~drv_q;
  endtask
endmodule

// *** dv/tb.sv ***
// Self-checking bench for the host bus port
`timescale 1ns/1ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin n_fail++; \
  $display("Error at %0t: got %h expected %h", $time, a, e); end end
module tb;
  logic                    clk = 1'b0;
  logic                    rst_n = 1'b0;
  logic                    clr_n = 1'b1;
  logic                    mode_e = 1'b0;
  logic                    cs_n, dtype, rd, wr, oe, wv, seen;
  logic [7:0]              bus, dout, q;
  hbid_pkg::hbid_wr_type   wbyte;
  hbid_pkg::hbid_kind_type kind;
  logic                    rds;
  int                      n_rds = 0;
  int                      n_fail = 0;
  int                      n_tests = 0;

  // 40 MHz clock
  always #12.5 clk = ~clk;

  hbid_host_model host (.clk_i(clk), .mode_e_i(mode_e), .dev_data_i(dout), .dev_oe_i(oe),
    .cs_n_o(cs_n), .dtype_o(dtype), .rd_o(rd), .wr_o(wr), .bus_o(bus));

  hbid_top DUT (.CLOCK_I(clk), .RST_N_I(rst_n), .CLK_EN_I(1'b1), .IFACE_PICK_A_I(mode_e),
    .IFACE_PICK_B_I(1'b0), .CHIP_SEL_N_I(cs_n), .DATA_TYPE_LINE_I(dtype),
    .RD_STROBE_N_OR_EN_I(rd), .WR_STROBE_N_OR_DIR_I(wr), .HW_CLEAR_IN_N_I(clr_n),
    .HOST_DATA_BUS_I(bus), .HOST_DATA_BUS_O(dout), .HOST_DATA_BUS_OE_O(oe),
    .STATUS_I(8'hA5), .RD_DATA_I(8'h3C), .WR_O(wbyte), .WR_VALID_O(wv), .KIND_O(kind),
    .RD_STROBE_O(rds));

  // Counts read start pulses seen at each sampling edge
  always @(posedge clk)
    if (rds === 1'b1)
      n_rds <= n_rds + 1;

  // Counts and verdict; the only place the run ends
  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Watches a bounded stretch for the write pulse instead of waiting open-ended
  task automatic wait_wv(input logic exp);
    seen = 1'b0;
    repeat (6)
    begin
      @(posedge clk);
      #1;
      seen |= (wv === 1'b1);
    end
    `CHK(seen, exp)
  endtask

  // Writes and reads of both data types in one bus style
  task automatic t_access(input logic m);
    logic [7:0] b;
    int         base;
    base = n_rds;
    @(posedge clk);
    mode_e <= m;
    for (int d = 0; d < 2; d++)
    begin
      b = d ? 8'h81 : 8'h7E;
      host.access(1'b1, d[0], 1'b1, b, q, seen);
      #1;
      `CHK(kind, d ? hbid_pkg::KIND_CMD_W : hbid_pkg::KIND_DATA_W)
      wait_wv(1'b1);
      `CHK(wbyte, {d[0], b})
      host.access(1'b0, d[0], 1'b1, 8'h00, q, seen);
      `CHK(seen, 1'b1)
      `CHK(q, d ? 8'h3C : 8'hA5)
      #1;
      `CHK(oe, 1'b0)
      `CHK(kind, d ? hbid_pkg::KIND_DATA_R : hbid_pkg::KIND_STATUS)
    end
    `CHK(n_rds - base, 2)
    $display("Test access in mode %0d done", m);
  endtask

  // Deselected write and read must leave no trace
  task automatic t_deselect();
    int base;
    base = n_rds;
    host.access(1'b1, 1'b0, 1'b0, 8'hF0, q, seen);
    wait_wv(1'b0);
    `CHK(wbyte, 9'h181)
    host.access(1'b0, 1'b1, 1'b0, 8'h00, q, seen);
    `CHK(seen, 1'b0)
    #1;
    `CHK(kind, hbid_pkg::KIND_IDLE)
    `CHK(n_rds - base, 0)
    $display("Test deselect done");
  endtask

  // Hardware clear wipes the captured byte and read data
  task automatic t_clear();
    @(posedge clk);
    clr_n <= 1'b0;
    @(posedge clk);
    #1;
    `CHK(wbyte, 9'h000)
    `CHK(dout, 8'h00)
    @(posedge clk);
    clr_n <= 1'b1;
    $display("Test clear done");
  endtask

  // Main sequence: reset, then each scenario in turn
  initial
  begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    t_access(1'b0);
    t_access(1'b1);
    t_deselect();
    t_clear();
    wrap_up();
  end
endmodule
